// *** rtl/pap_port.sv ***
// The register addresses and register access over Wishbone were chosen for this implementation.
`timescale 1ns/10ps
module pap_port #(
    parameter bit LARGE_PKG = 1'b1
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        clk_en,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // pads
    input  wire logic [7:0]  pad_in,
    output logic [7:0]       pad_out,
    output logic [7:0]       pad_oe,
    // remappable peripheral pins 0, 1, 5
    input  wire logic [2:0]  remap_out,
    output logic [2:0]       remap_in,
    // parallel port address bit 7
    input  wire logic        parallel_addr_bit7_out,
    output logic             parallel_addr_bit7_in,
    // serial slave select, active low
    output logic             serial_slave_select_n,
    // comparator reference output enable
    output logic             comparator_ref_out
);

    localparam int W = pap_pkg::PAP_PORT_W;

    logic [7:0] output_latch_reg;
    logic [7:0] direction_reg;
    logic [4:0] analog_pin_cfg;
    logic [7:0] ctrl_reg;
    logic       ack_reg;
    logic [31:0] rdata_reg;
    logic [7:0] pin_meta_reg;
    logic [7:0] pin_sync_reg;
    logic       clk_div_reg;
    logic [1:0] div_cnt_reg;

    logic [7:0] analog_vec;
    logic [7:0] osc_owned;
    logic [7:0] din_en;
    logic [7:0] drive_en;
    logic [7:0] out_val;
    logic [7:0] rd_bits;
    logic [7:0] wdata;
    logic       comparator_ref_out_en;
    logic       pmp_en;
    logic [2:0] remap_sel;
    logic       req;
    logic       wr_en;
    logic       clk_out_en;
    logic       take;
    logic       hit_pin_level;
    logic       hit_latch;
    logic       hit_dir;
    logic       hit_analog;
    logic       hit_ctrl;
    logic       wr_latch;
    logic       wr_dir;
    logic       wr_analog;
    logic       wr_ctrl;
    logic [31:0] rd_word;
    pap_pkg::pap_osc_mode_t osc_mode;

    assign wdata     = wb_dat_i[7:0];
    assign req       = wb_cyc_i & wb_stb_i;
    // write lands on the edge where the master sees ack
    assign wr_en     = clk_en & req & ack_reg & wb_we_i & wb_sel_i[0];
    assign comparator_ref_out_en  = ctrl_reg[pap_pkg::PAP_CTRL_COMPARATOR_REF_OUT];
    // parallel port exists only on the large package
    assign pmp_en    = ctrl_reg[pap_pkg::PAP_CTRL_PMP] & LARGE_PKG;
    assign remap_sel =
        ctrl_reg[pap_pkg::PAP_CTRL_RMP_HI:pap_pkg::PAP_CTRL_RMP_LO];
    assign osc_mode  = pap_pkg::pap_osc_mode_t'(
        ctrl_reg[pap_pkg::PAP_CTRL_OSC_HI:pap_pkg::PAP_CTRL_OSC_LO]);
    assign clk_out_en = (osc_mode == pap_pkg::PAP_OSC_RC) ||
                        (osc_mode == pap_pkg::PAP_OSC_EC);

    // request taken on the edge that raises ack
    assign take       = clk_en & req & ~ack_reg;

    // register decode, full byte address compare
    assign hit_pin_level = wb_adr_i == pap_pkg::PAP_OFS_PIN_LEVEL;
    assign hit_latch     = wb_adr_i == pap_pkg::PAP_OFS_LATCH;
    assign hit_dir       = wb_adr_i == pap_pkg::PAP_OFS_DIR;
    assign hit_analog    = wb_adr_i == pap_pkg::PAP_OFS_ANALOG;
    assign hit_ctrl      = wb_adr_i == pap_pkg::PAP_OFS_CTRL;

    // write strobes; port and latch offsets share the latch
    assign wr_latch  = wr_en & (hit_pin_level | hit_latch);
    assign wr_dir    = wr_en & hit_dir;
    assign wr_analog = wr_en & hit_analog;
    assign wr_ctrl   = wr_en & hit_ctrl;

    // wishbone ack, one cycle after the request, dropped after
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ack_reg <= 1'b0;
        end else if (clk_en) begin
            ack_reg <= req & ~ack_reg;
        end
    end

    // read word of the addressed register, zero when unmapped
    always_comb begin
        case (wb_adr_i)
            pap_pkg::PAP_OFS_PIN_LEVEL:
                rd_word = {24'h00_0000, rd_bits};
            pap_pkg::PAP_OFS_LATCH:
                rd_word = {24'h00_0000, output_latch_reg};
            pap_pkg::PAP_OFS_DIR:
                rd_word = {24'h00_0000, direction_reg};
            pap_pkg::PAP_OFS_ANALOG:
                rd_word = {27'h000_0000, analog_pin_cfg};
            pap_pkg::PAP_OFS_CTRL:
                rd_word = {24'h00_0000, ctrl_reg};
            default:
                rd_word = 32'h0000_0000;
        endcase
    end

    // read data captured together with ack
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (take) begin
            rdata_reg <= rd_word;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // output latch: port and latch offsets both write it
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            output_latch_reg <= pap_pkg::PAP_RST_LATCH;
        end else if (wr_latch) begin
            output_latch_reg <= wdata & pap_pkg::PAP_IMPL_MASK;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            direction_reg <= pap_pkg::PAP_RST_DIR;
        end else if (wr_dir) begin
            direction_reg <= wdata & pap_pkg::PAP_IMPL_MASK;
        end
    end

    // cfg bit 0 selects analog; reset leaves pins 0 to 3 and 5 analog
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            analog_pin_cfg <= pap_pkg::PAP_RST_ANALOG;
        end else if (wr_analog) begin
            analog_pin_cfg <= wdata[pap_pkg::PAP_CFG_W-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= pap_pkg::PAP_RST_CTRL;
        end else if (wr_ctrl) begin
            ctrl_reg <= wdata & pap_pkg::PAP_CTRL_MASK;
        end
    end

    // two-stage pad synchroniser
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pin_meta_reg <= 8'h00;
            pin_sync_reg <= 8'h00;
        end else if (clk_en) begin
            pin_meta_reg <= pad_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // instruction cycle clock, a quarter of the system clock
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            div_cnt_reg <= 2'h0;
            clk_div_reg <= 1'b0;
        end else if (clk_en) begin
            if (div_cnt_reg == 2'(pap_pkg::PAP_CLKOUT_HALF - 1)) begin
                div_cnt_reg <= 2'h0;
                clk_div_reg <= ~clk_div_reg;
            end else begin
                div_cnt_reg <= div_cnt_reg + 2'h1;
            end
        end
    end

    // per-pin function selection
    always_comb begin
        analog_vec = {2'b00, ~analog_pin_cfg[4], 1'b0,
                      ~analog_pin_cfg[3:0]};
        case (osc_mode)
            pap_pkg::PAP_OSC_HS:    osc_owned = 8'hc0;
            pap_pkg::PAP_OSC_RC:    osc_owned = 8'hc0;
            pap_pkg::PAP_OSC_EC:    osc_owned = 8'hc0;
            pap_pkg::PAP_OSC_INTIO: osc_owned = 8'h00;
            default:                osc_owned = 8'h00;
        endcase
    end

    // digital input path
    always_comb begin
        din_en = pap_pkg::PAP_IMPL_MASK & ~analog_vec & ~osc_owned;
        din_en[pap_pkg::PAP_PIN_COMPARATOR_REF_OUT] =
            din_en[pap_pkg::PAP_PIN_COMPARATOR_REF_OUT] & ~comparator_ref_out_en;
    end

    // output driver: analog selection has no effect here
    always_comb begin
        drive_en = pap_pkg::PAP_IMPL_MASK & ~direction_reg
                   & ~osc_owned;
        drive_en[pap_pkg::PAP_PIN_COMPARATOR_REF_OUT] =
            drive_en[pap_pkg::PAP_PIN_COMPARATOR_REF_OUT] & ~comparator_ref_out_en;
        // clock output overrides the direction bit
        drive_en[pap_pkg::PAP_PIN_CLKOUT] =
            clk_out_en | drive_en[pap_pkg::PAP_PIN_CLKOUT];
    end

    // output value: latch unless a peripheral owns the pin
    always_comb begin
        out_val = output_latch_reg;
        if (remap_sel[0]) begin
            out_val[0] = remap_out[0];
        end
        // parallel address wins over remap on pin 1
        if (pmp_en) begin
            out_val[pap_pkg::PAP_PIN_PARALLEL_ADDR_BIT7] = parallel_addr_bit7_out;
        end else if (remap_sel[1]) begin
            out_val[pap_pkg::PAP_PIN_PARALLEL_ADDR_BIT7] = remap_out[1];
        end
        if (remap_sel[2]) begin
            out_val[pap_pkg::PAP_PIN_SS] = remap_out[2];
        end
        if (clk_out_en) begin
            out_val[pap_pkg::PAP_PIN_CLKOUT] = clk_div_reg;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_pin
            pap_pin_cell u_cell (
                .ref_clk  (ref_clk),
                .nrst     (nrst),
                .clk_en   (clk_en),
                .drive_en (drive_en[gi]),
                .out_val  (out_val[gi]),
                .din_en   (din_en[gi]),
                .pin_sync (pin_sync_reg[gi]),
                .pad_out  (pad_out[gi]),
                .pad_oe   (pad_oe[gi]),
                .rd_bit   (rd_bits[gi])
            );
        end
    endgenerate

    // peripheral inputs, taken only while the direction bit is set
    always_comb begin
        remap_in[0] = direction_reg[0] & rd_bits[0];
        remap_in[1] = direction_reg[1] & rd_bits[1];
        remap_in[2] = direction_reg[pap_pkg::PAP_PIN_SS]
                      & rd_bits[pap_pkg::PAP_PIN_SS];
        parallel_addr_bit7_in = pmp_en
            & direction_reg[pap_pkg::PAP_PIN_PARALLEL_ADDR_BIT7]
            & rd_bits[pap_pkg::PAP_PIN_PARALLEL_ADDR_BIT7];
    end

    // select reads deasserted while pin 5 is no digital input
    assign serial_slave_select_n =
        ~(direction_reg[pap_pkg::PAP_PIN_SS]
          & din_en[pap_pkg::PAP_PIN_SS])
        | pin_sync_reg[pap_pkg::PAP_PIN_SS];
    assign comparator_ref_out = comparator_ref_out_en;

endmodule : pap_port

// *** pkg/pap_pkg.sv ***
package pap_pkg;

    // register word offsets (byte addresses)
    localparam logic [7:0] PAP_OFS_PIN_LEVEL = 8'h00;
    localparam logic [7:0] PAP_OFS_LATCH     = 8'h04;
    localparam logic [7:0] PAP_OFS_DIR       = 8'h08;
    localparam logic [7:0] PAP_OFS_ANALOG    = 8'h0c;
    localparam logic [7:0] PAP_OFS_CTRL      = 8'h10;

    // port geometry
    localparam int PAP_PORT_W  = 8;
    localparam int PAP_HOLE    = 4;
    localparam int PAP_CFG_W   = 5;
    localparam int PAP_REMAP_N = 3;

    // pins with special functions
    localparam int PAP_PIN_PARALLEL_ADDR_BIT7   = 1;
    localparam int PAP_PIN_COMPARATOR_REF_OUT  = 2;
    localparam int PAP_PIN_SS     = 5;
    localparam int PAP_PIN_CLKOUT = 6;
    localparam int PAP_PIN_OSCIN  = 7;

    // implemented port positions, position 4 missing
    localparam logic [7:0] PAP_IMPL_MASK = 8'hef;

    // control register fields
    localparam int PAP_CTRL_COMPARATOR_REF_OUT   = 0;
    localparam int PAP_CTRL_OSC_LO  = 1;
    localparam int PAP_CTRL_OSC_HI  = 2;
    localparam int PAP_CTRL_PMP     = 3;
    localparam int PAP_CTRL_RMP_LO  = 4;
    localparam int PAP_CTRL_RMP_HI  = 6;
    localparam logic [7:0] PAP_CTRL_MASK = 8'h7f;

    // reset values
    localparam logic [7:0] PAP_RST_LATCH  = 8'h00;
    localparam logic [7:0] PAP_RST_DIR    = 8'hef;
    localparam logic [4:0] PAP_RST_ANALOG = 5'h00;
    localparam logic [7:0] PAP_RST_CTRL   = 8'h00;

    // cycle clock output is the system clock divided by four
    localparam int PAP_CLKOUT_DIV  = 4;
    localparam int PAP_CLKOUT_HALF = PAP_CLKOUT_DIV / 2;

    typedef enum logic [1:0] {
        PAP_OSC_INTIO,
        PAP_OSC_HS,
        PAP_OSC_RC,
        PAP_OSC_EC
    } pap_osc_mode_t;

endpackage : pap_pkg

// *** rtl/pap_pin_cell.sv ***
`timescale 1ns/10ps
module pap_pin_cell (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic clk_en,
    // control from the port
    input  wire logic drive_en,
    input  wire logic out_val,
    input  wire logic din_en,
    input  wire logic pin_sync,
    // pad side
    output logic      pad_out,
    output logic      pad_oe,
    // read path
    output logic      rd_bit
);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pad_out <= 1'b0;
            pad_oe  <= 1'b0;
        end else if (clk_en) begin
            pad_out <= out_val;
            pad_oe  <= drive_en;
        end
    end

    // disabled digital input reads as zero
    assign rd_bit = din_en & pin_sync;

endmodule : pap_pin_cell

// *** sim/pap_port_asserts.sv ***
`timescale 1ns/10ps
module pap_port_asserts (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic        clk_en,
    // register bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // pads
    input wire logic [7:0]  pad_oe,
    input wire logic        comparator_ref_out
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic [7:0] latch_reg;
    logic       lat_wr;
    assign lat_wr = clk_en && wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i
                    && wb_sel_i[0] && wb_adr_i[7:3] == 5'h00;
    // latch as software wrote it
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            latch_reg <= 8'h00;
        end else if (lat_wr && wb_adr_i[1:0] == 2'h0) begin
            latch_reg <= wb_dat_i[7:0] & 8'hef;
        end
    end
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("late ack");
    property p_ack_pulse;
        wb_ack_o && clk_en |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
    property p_ack_cause;
        $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    property p_reset_idle;
        $rose(nrst) |-> (pad_oe == 8'h00) [*4];
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("drive");
    property p_hole;
        wb_ack_o && !wb_we_i && wb_adr_i <= 8'h08
            |-> !wb_dat_o[4] && !pad_oe[4];
    endproperty
    a_hole: assert property (p_hole) else $error("bit 4 seen");
    property p_dir_oe;
        wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h08
            |-> ##2 pad_oe[0] == !$past(wb_dat_i[0], 2);
    endproperty
    a_dir_oe: assert property (p_dir_oe) else $error("pad 0 drive");
    property p_comparator_ref_out;
        comparator_ref_out && $past(comparator_ref_out) |-> !pad_oe[2];
    endproperty
    a_comparator_ref_out: assert property (p_comparator_ref_out) else $error("pad 2 driven");
    property p_latch_rd;
        wb_ack_o && !wb_we_i && wb_adr_i == 8'h04
            |-> wb_dat_o == {24'h000000, latch_reg};
    endproperty
    a_latch_rd: assert property (p_latch_rd) else $error("latch rd");
    property p_freeze;
        !clk_en |=> $stable(pad_oe) && $stable(wb_ack_o);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved");
    c_dir_wr: cover property (wb_ack_o && wb_we_i && wb_adr_i == 8'h08);
    c_lat_rd: cover property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h04);
    c_comparator_ref_out: cover property (comparator_ref_out && $past(comparator_ref_out));
    c_hold: cover property (!clk_en);
endmodule : pap_port_asserts

bind pap_port pap_port_asserts pap_port_asserts_i (
    .ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pad_oe(pad_oe),
    .comparator_ref_out(comparator_ref_out)
);

// *** sim/tb_port_a_pin_control.sv ***
`timescale 1ns/10ps
module tb_port_a_pin_control;
    logic        ref_clk, nrst, clk_en, cyc, stb, we, ack, pa7_o, pa7_i;
    logic        ss_n, cref;
    logic [7:0]  adr, pad_in, pad_out, pad_oe, q;
    logic [3:0]  sel;
    logic [31:0] dat, dat_o;
    logic [2:0]  rm_o, rm_i;
    int          n_fail, checked;

    pap_port pap_port_i (
        .ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .remap_out(rm_o),
        .remap_in(rm_i), .parallel_addr_bit7_out(pa7_o),
        .parallel_addr_bit7_in(pa7_i), .serial_slave_select_n(ss_n),
        .comparator_ref_out(cref));

    always #5 ref_clk = ~ref_clk;

    task automatic complete_run;
        if (n_fail == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] s);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h000000, d};
        do begin
            @(posedge ref_clk);
            n++;
            if (n > 20) begin
                n_fail++;
                $display("Error ack expected 1 seen %b", ack);
                complete_run();
            end
        end while (ack !== 1'b1);
        q = dat_o[7:0];
        {cyc, stb} <= 2'b00;
    endtask : wb

    task automatic settle;
        repeat (3) @(negedge ref_clk);
    endtask : settle

    task automatic t_reset;
        logic [7:0] ad[6] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h00, 8'h20};
        logic [7:0] ex[6] = '{8'h00, 8'hef, 8'h00, 8'h00, 8'hc0, 8'h00};
        for (int i = 0; i < 6; i++) begin
            wb(1'b0, ad[i], 8'h00);
            chk("reset read", ex[i], q);
        end
    endtask : t_reset

    task automatic t_latch;
        wb(1'b1, 8'h00, 8'hff);
        wb(1'b0, 8'h04, 8'h00);
        chk("latch", 8'hef, q);
        wb(1'b1, 8'h04, 8'h5a);
        wb(1'b1, 8'h08, 8'h00);
        settle;
        chk("pad_oe", 8'hef, pad_oe);
        chk("pad_out", 8'h4a, pad_out);
        wb(1'b0, 8'h00, 8'h00);
        chk("analog pins", 8'hc0, q);
        wb(1'b1, 8'h0c, 8'h1f);
        pad_in <= 8'h96;
        sel <= 4'h0;
        wb(1'b1, 8'h04, 8'h00);
        sel <= 4'h1;
        settle;
        wb(1'b0, 8'h00, 8'h00);
        chk("pins", 8'h86, q);
        wb(1'b0, 8'h04, 8'h00);
        chk("latch kept", 8'h4a, q);
    endtask : t_latch

    task automatic t_comparator_ref_out;
        wb(1'b1, 8'h10, 8'h01);
        settle;
        chk("ref out", 8'h01, {7'h00, cref});
        chk("pad2 oe", 8'h00, {7'h00, pad_oe[2]});
        wb(1'b0, 8'h00, 8'h00);
        chk("pad2 read", 8'h82, q);
    endtask : t_comparator_ref_out

    task automatic t_clkout;
        int   cnt;
        logic prev;
        wb(1'b1, 8'h08, 8'hff);
        for (int m = 1; m < 4; m++) begin
            wb(1'b1, 8'h10, 8'(m << 1));
            settle;
            cnt = 0;
            prev = pad_out[6];
            repeat (8) begin
                @(negedge ref_clk);
                cnt += int'(pad_out[6] !== prev);
                prev = pad_out[6];
            end
            chk("clk oe", 8'(m > 1), {7'h00, pad_oe[6]});
            chk("clk edges", (m > 1) ? 8'h04 : 8'h00, 8'(cnt));
        end
        @(posedge ref_clk);
        clk_en <= 1'b0;
        @(negedge ref_clk);
        cnt = 0;
        prev = pad_out[6];
        repeat (8) begin
            @(negedge ref_clk);
            cnt += int'(pad_out[6] !== prev);
        end
        chk("held clk", 8'h00, 8'(cnt));
        @(posedge ref_clk);
        clk_en <= 1'b1;
    endtask : t_clkout

    task automatic t_remap;
        wb(1'b1, 8'h10, 8'h70);
        wb(1'b1, 8'h08, 8'h22);
        rm_o <= 3'b101;
        pad_in <= 8'h02;
        settle;
        chk("remap oe", 8'h01, {5'h00, pad_oe[5], pad_oe[1:0]});
        chk("remap out", 8'h01, {7'h00, pad_out[0]});
        chk("remap in", 8'h02, {5'h00, rm_i});
        chk("select", 8'h00, {7'h00, ss_n});
        @(posedge ref_clk);
        pad_in <= 8'h22;
        settle;
        chk("remap in 5", 8'h06, {5'h00, rm_i});
        chk("select off", 8'h01, {7'h00, ss_n});
    endtask : t_remap

    task automatic t_pmp;
        wb(1'b1, 8'h10, 8'h08);
        wb(1'b1, 8'h08, 8'h00);
        settle;
        chk("addr out", 8'h02, {6'h00, pad_oe[1], pad_out[1]});
        wb(1'b1, 8'h08, 8'h02);
        settle;
        chk("addr in", 8'h01, {6'h00, pad_oe[1], pa7_i});
    endtask : t_pmp

    initial begin
        {ref_clk, nrst, clk_en, cyc, stb, we, pa7_o} = 7'h10;
        {adr, dat, rm_o} = '0;
        sel = 4'h1;
        pad_in = 8'hff;
        n_fail = 0;
        checked = 0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        t_reset;
        t_latch;
        t_comparator_ref_out;
        t_clkout;
        t_remap;
        t_pmp;
        complete_run;
    end
endmodule : tb_port_a_pin_control
